// *** lcd_pkg.sv ***
package lcd_pkg;
  // data path widths
  localparam int WORD_W = 32;
  localparam int BUF_W = 64;
  localparam int ACC_W = 24;
  localparam int RGB_W = 24;
  localparam int BUS_W = 8;
  // timing field widths
  localparam int DIV_W = 10;
  localparam int CNT_W = 11;
  localparam int PORCH_W = 8;
  // storage sizes
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int PAL_DEPTH = 256;
  localparam int PAL_W = 16;
  localparam int PAL_IDX_W = 8;
  // passive panel data modes
  localparam logic [2:0] STN_MONO = 3'h0;
  localparam logic [2:0] STN_GRAY4 = 3'h1;
  localparam logic [2:0] STN_GRAY16 = 3'h2;
  localparam logic [2:0] STN_C256 = 3'h3;
  localparam logic [2:0] STN_C12P = 3'h4;
  localparam logic [2:0] STN_C12U = 3'h5;
  localparam logic [2:0] STN_C16 = 3'h6;
  // active panel pixel depths
  localparam logic [2:0] TFT_BPP1 = 3'h0;
  localparam logic [2:0] TFT_BPP2 = 3'h1;
  localparam logic [2:0] TFT_BPP4 = 3'h2;
  localparam logic [2:0] TFT_BPP8 = 3'h3;
  localparam logic [2:0] TFT_BPP16 = 3'h4;
  localparam logic [2:0] TFT_BPP24 = 3'h5;
  // bits taken from the word stream per unpack step
  localparam logic [6:0] POP_1 = 7'h01;
  localparam logic [6:0] POP_2 = 7'h02;
  localparam logic [6:0] POP_4 = 7'h04;
  localparam logic [6:0] POP_8 = 7'h08;
  localparam logic [6:0] POP_12 = 7'h0C;
  localparam logic [6:0] POP_16 = 7'h10;
  localparam logic [6:0] POP_32 = 7'h20;
  localparam logic [6:0] REFILL_LIMIT = 7'h20;
  // panel bit staging
  localparam logic [4:0] BEAT_NARROW = 5'h04;
  localparam logic [4:0] BEAT_WIDE = 5'h08;
  localparam logic [4:0] ACC_ROOM = 5'h10;
  // reset values
  localparam logic AC_BIAS_RST = 1'b0;
  localparam logic PCLK_RST = 1'b0;
  // line and frame phases
  typedef enum logic [1:0] {PH_SYNC, PH_BACK, PH_ACTIVE, PH_FRONT} phase_t;
endpackage

// *** lcd_word_fifo.sv ***
`timescale 1ns/10ps
module lcd_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // word storage
  logic [AW-1:0] wr_ptr;  // next slot to fill
  logic [AW-1:0] rd_ptr;  // oldest word
  logic [AW:0] count;  // words held
  logic push;
  logic pull;
  logic [AW:0] next_count;

  // handshakes on both sides
  always_comb begin
    push = in_valid && in_ready;
    pull = out_valid && out_ready;
    next_count = count + (AW+1)'(push) - (AW+1)'(pull);
  end

  // storage and pointers; wrap assumes a power-of-two depth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pull) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      // registered ready, taken from the next count
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
endmodule

// *** lcd_palette.sv ***
`timescale 1ns/10ps
module lcd_palette #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 16
) (
  // clock
  input wire logic clk,
  // software write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_index,
  input wire logic [WIDTH-1:0] wr_color,
  // unclocked lookup, so the pixel stage needs no extra slot
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic [WIDTH-1:0] rd_color
);
  logic [WIDTH-1:0] table_mem [DEPTH];  // 5:6:5 entries, undefined until written

  // entry write; no reset, software loads the table
  always_ff @(posedge clk) begin
    if (wr_en) begin
      table_mem[wr_index] <= wr_color;
    end
  end

  assign rd_color = table_mem[rd_index];
endmodule

// *** lcd_pixel_unpack_and_timing.sv ***
`timescale 1ns/10ps
// Contract
// - mono words leave msb first, in order
// - four-gray mode: two bits per pixel
// - sixteen-gray mode: four bits per pixel
// - 256-color byte: red 7:5, green 4:2, blue
// - packed 12-bit: eight pixels per three words
// - unpacked 12-bit: two pixels, top nibbles ignored
// - 16-bit 5:6:5, first pixel upper half
// - passive 16-bit uses the top bit of each colour
// - data on 8-bit bus, panel clocks it
// - line pulse after each shifted line
// - ac bias toggles per frame or lines
// - timing generator makes syncs, clock, enable
// - vertical sync starts each frame
// - pixel clock is clk over 2(div+1)
// - frame and line lengths from phase fields
// - active panel 1/2/4/8/16/24 bits per pixel
// - 256-entry palette maps indexed pixels
// - four-bit scan drives low four lines
// - eight-bit scan drives all eight lines
module lcd_pixel_unpack_and_timing
  import lcd_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // video words from the memory fetcher
  input wire logic [WORD_W-1:0] word_data,
  input wire logic word_valid,
  output logic word_ready,
  // mode selection
  input wire logic display_enable,
  input wire logic panel_is_tft,
  input wire logic [2:0] stn_mode,
  input wire logic stn_bus8,
  input wire logic [2:0] tft_bpp,
  // timing fields
  input wire logic [DIV_W-1:0] pixel_clk_divider,
  input wire logic [CNT_W-1:0] horiz_size_m1,
  input wire logic [CNT_W-1:0] vert_size_m1,
  input wire logic [PORCH_W-1:0] hsync_width,
  input wire logic [PORCH_W-1:0] horiz_back_porch,
  input wire logic [PORCH_W-1:0] horiz_front_porch,
  input wire logic [PORCH_W-1:0] vsync_width,
  input wire logic [PORCH_W-1:0] vert_back_porch,
  input wire logic [PORCH_W-1:0] vert_front_porch,
  // ac bias setup
  input wire logic ac_bias_per_frame,
  input wire logic [PORCH_W-1:0] ac_bias_line_count,
  // palette write port
  input wire logic pal_write,
  input wire logic [PAL_IDX_W-1:0] pal_index,
  input wire logic [PAL_W-1:0] pal_color,
  // status
  input wire logic underrun_clear,
  output logic underrun_flag,
  // panel pins
  output logic [BUS_W-1:0] video_data_bus,
  output logic [RGB_W-1:0] tft_rgb,
  output logic pixel_clock,
  output logic line_pulse,
  output logic frame_sync,
  output logic data_enable_out,
  output logic line_end_pulse,
  output logic ac_bias_output
);
  // word fifo drain side
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  // pixel clock divider
  logic [DIV_W-1:0] div_cnt;  // clocks into the half period
  logic beat;  // this edge drops the pixel clock
  // raster position
  phase_t h_phase;
  phase_t v_phase;
  logic [CNT_W-1:0] h_cnt;
  logic [CNT_W-1:0] v_cnt;
  logic in_active;
  logic line_start;
  logic frame_start;
  // ac bias line counter
  logic [PORCH_W-1:0] bias_lines;
  // word bit buffer, left justified
  logic [BUF_W-1:0] bit_buf;
  logic [6:0] bit_cnt;
  // passive panel bit staging, left justified
  logic [ACC_W-1:0] acc;
  logic [4:0] acc_cnt;
  // one active panel pixel held ready
  logic [RGB_W-1:0] tft_hold;
  logic tft_full;
  // unpack decisions
  logic [6:0] pop_w;
  logic [BUS_W-1:0] stn_bits;  // new panel bits, left justified
  logic [4:0] beat_n;
  logic stn_take;
  logic tft_take;
  logic stn_short;
  logic pop;
  logic refill;
  logic [ACC_W-1:0] acc_left;
  logic [4:0] acc_left_cnt;
  logic [BUF_W-1:0] buf_left;
  logic [6:0] cnt_left;
  logic [WORD_W-1:0] top32;
  logic [PAL_IDX_W-1:0] pal_rd_index;
  logic [PAL_W-1:0] pal_rd_color;
  logic [RGB_W-1:0] tft_pix;
  logic [PAL_W-1:0] c565;

  // length minus one of each horizontal phase
  function automatic logic [CNT_W-1:0] h_len(input phase_t ph);
    case (ph)
      PH_SYNC: h_len = CNT_W'(hsync_width);
      PH_BACK: h_len = CNT_W'(horiz_back_porch);
      PH_ACTIVE: h_len = horiz_size_m1;
      default: h_len = CNT_W'(horiz_front_porch);
    endcase
  endfunction

  // length minus one of each vertical phase, in lines
  function automatic logic [CNT_W-1:0] v_len(input phase_t ph);
    case (ph)
      PH_SYNC: v_len = CNT_W'(vsync_width);
      PH_BACK: v_len = CNT_W'(vert_back_porch);
      PH_ACTIVE: v_len = vert_size_m1;
      default: v_len = CNT_W'(vert_front_porch);
    endcase
  endfunction

  lcd_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(word_data),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  lcd_palette #(
    .DEPTH(PAL_DEPTH),
    .WIDTH(PAL_W)
  ) u_palette (
    .clk(clk),
    .wr_en(pal_write),
    .wr_index(pal_index),
    .wr_color(pal_color),
    .rd_index(pal_rd_index),
    .rd_color(pal_rd_color)
  );

  // pixel clock: toggles every div+1 clocks, data changes on its fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      pixel_clock <= PCLK_RST;
    end else if (!display_enable) begin
      div_cnt <= '0;
      pixel_clock <= PCLK_RST;
    end else if (div_cnt == pixel_clk_divider) begin
      div_cnt <= '0;
      pixel_clock <= !pixel_clock;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // position decode for the beat being sent now
  always_comb begin
    beat = display_enable && pixel_clock && (div_cnt == pixel_clk_divider);
    in_active = (h_phase == PH_ACTIVE) && (v_phase == PH_ACTIVE);
    line_start = (h_phase == PH_SYNC) && (h_cnt == '0);
    frame_start = line_start && (v_phase == PH_SYNC) && (v_cnt == '0);
  end

  // raster counters: sync, back porch, active, front porch in both axes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_phase <= PH_SYNC;
      v_phase <= PH_SYNC;
      h_cnt <= '0;
      v_cnt <= '0;
    end else if (!display_enable) begin
      h_phase <= PH_SYNC;
      v_phase <= PH_SYNC;
      h_cnt <= '0;
      v_cnt <= '0;
    end else if (beat) begin
      if (h_cnt == h_len(h_phase)) begin
        h_cnt <= '0;
        h_phase <= phase_t'(h_phase + 2'h1);
        if (h_phase == PH_FRONT) begin
          // a full line has passed: step the vertical position
          if (v_cnt == v_len(v_phase)) begin
            v_cnt <= '0;
            v_phase <= phase_t'(v_phase + 2'h1);
          end else begin
            v_cnt <= v_cnt + 1'b1;
          end
        end
      end else begin
        h_cnt <= h_cnt + 1'b1;
      end
    end
  end

  // sync, enable and line end pins, moved on each beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_pulse <= 1'b0;
      frame_sync <= 1'b0;
      data_enable_out <= 1'b0;
      line_end_pulse <= 1'b0;
    end else if (!display_enable) begin
      line_pulse <= 1'b0;
      frame_sync <= 1'b0;
      data_enable_out <= 1'b0;
      line_end_pulse <= 1'b0;
    end else if (beat) begin
      // the sync phase follows the front porch, so the pulse lands after the line
      line_pulse <= (h_phase == PH_SYNC);
      frame_sync <= (v_phase == PH_SYNC);
      data_enable_out <= in_active;
      line_end_pulse <= (h_phase == PH_FRONT) && (h_cnt == '0);
    end
  end

  // ac bias: flips per frame or every ac_bias_line_count+1 lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ac_bias_output <= AC_BIAS_RST;
      bias_lines <= '0;
    end else if (!display_enable) begin
      ac_bias_output <= AC_BIAS_RST;
      bias_lines <= '0;
    end else if (beat) begin
      if (ac_bias_per_frame) begin
        bias_lines <= '0;
        if (frame_start) begin
          ac_bias_output <= !ac_bias_output;
        end
      end else if (line_start) begin
        if (bias_lines == ac_bias_line_count) begin
          bias_lines <= '0;
          ac_bias_output <= !ac_bias_output;
        end else begin
          bias_lines <= bias_lines + 1'b1;
        end
      end
    end
  end

  // unpack step: field width, then panel bits or an rgb pixel
  always_comb begin
    top32 = bit_buf[BUF_W-1 -: WORD_W];
    stn_bits = '0;
    beat_n = stn_bus8 ? BEAT_WIDE : BEAT_NARROW;
    pal_rd_index = top32[31:24];
    tft_pix = '0;
    c565 = top32[31:16];
    if (!panel_is_tft) begin
      // one byte or one pixel per step; only colour msbs reach the panel
      case (stn_mode)
        STN_MONO: begin
          pop_w = POP_8;
          stn_bits = top32[31:24];
        end
        STN_GRAY4: begin
          pop_w = POP_8;
          stn_bits = {top32[31], top32[29], top32[27], top32[25], 4'h0};
        end
        STN_GRAY16: begin
          pop_w = POP_8;
          stn_bits = {top32[31], top32[27], 6'h00};
        end
        STN_C256: begin
          pop_w = POP_8;
          stn_bits = {top32[31], top32[28], top32[25], 5'h00};
        end
        STN_C12P: begin
          pop_w = POP_12;
          stn_bits = {top32[31], top32[27], top32[23], 5'h00};
        end
        STN_C12U: begin
          pop_w = POP_16;
          stn_bits = {top32[27], top32[23], top32[19], 5'h00};
        end
        default: begin
          pop_w = POP_16;
          stn_bits = {top32[31], top32[26], top32[20], 5'h00};
        end
      endcase
    end else begin
      case (tft_bpp)
        TFT_BPP1: begin
          pop_w = POP_1;
          pal_rd_index = {7'h00, top32[31]};
        end
        TFT_BPP2: begin
          pop_w = POP_2;
          pal_rd_index = {6'h00, top32[31:30]};
        end
        TFT_BPP4: begin
          pop_w = POP_4;
          pal_rd_index = {4'h0, top32[31:28]};
        end
        TFT_BPP8: begin
          pop_w = POP_8;
        end
        TFT_BPP16: begin
          pop_w = POP_16;
        end
        default: begin
          pop_w = POP_32;  // top byte of the word is a dummy
        end
      endcase
      // indexed depths use the palette, 16-bit widens directly
      if (tft_bpp <= TFT_BPP8) begin
        c565 = pal_rd_color;
      end
      if (tft_bpp == TFT_BPP24) begin
        tft_pix = top32[23:0];
      end else begin
        tft_pix = {c565[15:11], c565[15:13], c565[10:5], c565[10:9], c565[4:0], c565[4:2]};
      end
    end
  end

  // flow control between word buffer, staging and the beats
  always_comb begin
    stn_take = beat && in_active && !panel_is_tft;
    tft_take = beat && in_active && panel_is_tft;
    stn_short = (acc_cnt < beat_n);
    acc_left = acc;
    acc_left_cnt = acc_cnt;
    if (stn_take && !stn_short) begin
      acc_left = acc << beat_n;
      acc_left_cnt = acc_cnt - beat_n;
    end
    if (panel_is_tft) begin
      pop = (bit_cnt >= pop_w) && (!tft_full || tft_take);
    end else begin
      pop = (bit_cnt >= pop_w) && (acc_left_cnt <= ACC_ROOM);
    end
    buf_left = pop ? (bit_buf << pop_w) : bit_buf;
    cnt_left = pop ? (bit_cnt - pop_w) : bit_cnt;
    // a word joins only if it fits behind what is left
    refill = fifo_valid && (cnt_left <= REFILL_LIMIT);
    fifo_ready = refill && display_enable;
  end

  // words enter behind earlier bits so fields may span words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_buf <= '0;
      bit_cnt <= '0;
    end else if (!display_enable) begin
      bit_buf <= '0;
      bit_cnt <= '0;
    end else if (refill) begin
      bit_buf <= buf_left | ({fifo_data, 32'h0000_0000} >> cnt_left);
      bit_cnt <= cnt_left + REFILL_LIMIT;
    end else begin
      bit_buf <= buf_left;
      bit_cnt <= cnt_left;
    end
  end

  // passive staging: bits wait until a beat takes four or eight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      acc_cnt <= '0;
    end else if (!display_enable || panel_is_tft) begin
      acc <= '0;
      acc_cnt <= '0;
    end else if (pop) begin
      acc <= acc_left | ({stn_bits, 16'h0000} >> acc_left_cnt);
      acc_cnt <= acc_left_cnt + ((stn_mode == STN_MONO) ? 5'h08 : (stn_mode == STN_GRAY4) ? 5'h04 :
                                 (stn_mode == STN_GRAY16) ? 5'h02 : 5'h03);
    end else begin
      acc <= acc_left;
      acc_cnt <= acc_left_cnt;
    end
  end

  // active panel hold: one converted pixel waits for its beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tft_hold <= '0;
      tft_full <= 1'b0;
    end else if (!display_enable || !panel_is_tft) begin
      tft_hold <= '0;
      tft_full <= 1'b0;
    end else if (pop) begin
      tft_hold <= tft_pix;
      tft_full <= 1'b1;
    end else if (tft_take) begin
      tft_full <= 1'b0;
    end
  end

  // data pins change with the pixel clock fall; blanking drives zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      video_data_bus <= '0;
      tft_rgb <= '0;
    end else if (!display_enable) begin
      video_data_bus <= '0;
      tft_rgb <= '0;
    end else if (beat) begin
      if (stn_take && !stn_short) begin
        video_data_bus <= stn_bus8 ? acc[ACC_W-1 -: 8] : {4'h0, acc[ACC_W-1 -: 4]};
      end else begin
        video_data_bus <= '0;
      end
      tft_rgb <= (tft_take && tft_full) ? tft_hold : '0;
    end
  end

  // underrun: a beat in the active region found no data; set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      underrun_flag <= 1'b0;
    end else if ((stn_take && stn_short) || (tft_take && !tft_full)) begin
      underrun_flag <= 1'b1;
    end else if (underrun_clear) begin
      underrun_flag <= 1'b0;
    end
  end
endmodule

// *** lcd_pixel_unpack_and_timing_checker.sv ***
`timescale 1ns/10ps
module lcd_pixel_unpack_and_timing_checker
  import lcd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controls watched
  input wire logic display_enable,
  input wire logic panel_is_tft,
  input wire logic stn_bus8,
  input wire logic [DIV_W-1:0] pixel_clk_divider,
  // panel pins
  input wire logic [BUS_W-1:0] video_data_bus,
  input wire logic [RGB_W-1:0] tft_rgb,
  input wire logic pixel_clock,
  input wire logic line_pulse,
  input wire logic frame_sync,
  input wire logic data_enable_out,
  input wire logic line_end_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // clk cycles since the last pixel clock edge
  logic [DIV_W-1:0] half_cnt;
  // first half period after enable is not judged
  logic half_ok;
  // restarted by every pixel clock edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_cnt <= '0;
      half_ok <= 1'b0;
    end else if (!display_enable) begin
      half_cnt <= '0;
      half_ok <= 1'b0;
    end else if ($changed(pixel_clock)) begin
      half_cnt <= '0;
      half_ok <= 1'b1;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end
  pclk_half_a: assert property (display_enable && half_ok && $changed(pixel_clock) |->
    half_cnt == pixel_clk_divider) else $error("pixel clock half period wrong");
  de_blank_a: assert property (data_enable_out |-> !line_pulse && !frame_sync)
    else $error("data enable during sync");
  de_on_beat_a: assert property (display_enable && $changed(data_enable_out) |-> $fell(pixel_clock))
    else $error("data enable moved off a beat");
  frame_start_a: assert property ($rose(frame_sync) |-> $rose(line_pulse))
    else $error("frame sync not at line start");
  line_end_a: assert property (display_enable && $fell(data_enable_out) |-> $rose(line_end_pulse))
    else $error("line end missing after active");
  line_after_a: assert property (disable iff (rst || !display_enable)
    $fell(data_enable_out) |-> ##[1:1000] $rose(line_pulse)) else $error("no line pulse after line");
  low_nibble_a: assert property (!panel_is_tft && !stn_bus8 |-> video_data_bus[7:4] == 4'h0)
    else $error("upper lines driven in narrow mode");
  pins_idle_a: assert property (!data_enable_out |-> video_data_bus == 8'h00 && tft_rgb == 24'h000000)
    else $error("data pins busy outside active");
endmodule
bind lcd_pixel_unpack_and_timing lcd_pixel_unpack_and_timing_checker chk (.clk(clk), .rst(rst),
  .display_enable(display_enable), .panel_is_tft(panel_is_tft), .stn_bus8(stn_bus8),
  .pixel_clk_divider(pixel_clk_divider), .video_data_bus(video_data_bus), .tft_rgb(tft_rgb),
  .pixel_clock(pixel_clock), .line_pulse(line_pulse), .frame_sync(frame_sync),
  .data_enable_out(data_enable_out), .line_end_pulse(line_end_pulse));

// *** lcd_panel_model.sv ***
`timescale 1ns/10ps
module lcd_panel_model
  import lcd_pkg::*;
(
  // panel pins from the controller
  input wire logic pixel_clock,
  input wire logic data_enable_out,
  input wire logic [BUS_W-1:0] video_data_bus,
  input wire logic [RGB_W-1:0] tft_rgb
);
  // captured beats, oldest first
  logic [BUS_W-1:0] byte_q[$];
  logic [RGB_W-1:0] rgb_q[$];
  // capture on the rising pixel clock, mid beat
  always @(posedge pixel_clock) begin
    if (data_enable_out) begin
      byte_q.push_back(video_data_bus);
      rgb_q.push_back(tft_rgb);
    end
  end
endmodule

// *** lcd_pixel_unpack_and_timing_tb.sv ***
`timescale 1ns/10ps
module lcd_pixel_unpack_and_timing_tb
  import lcd_pkg::*;
;
  // clock, reset and word stream
  logic clk = 1'b0, rst = 1'b1, word_valid = 1'b0, word_ready;
  logic [WORD_W-1:0] word_data = '0;
  // mode selection
  logic display_enable = 1'b0, panel_is_tft = 1'b0, stn_bus8 = 1'b0;
  logic [2:0] stn_mode = 3'h0, tft_bpp = 3'h0;
  // timing fields: 12 beat line, 5 line frame
  logic [DIV_W-1:0] pixel_clk_divider = 10'h003;
  logic [CNT_W-1:0] horiz_size_m1 = 11'h007, vert_size_m1 = 11'h001;
  logic [PORCH_W-1:0] hsync_width = 8'h00, horiz_back_porch = 8'h01, horiz_front_porch = 8'h00;
  logic [PORCH_W-1:0] vsync_width = 8'h00, vert_back_porch = 8'h00, vert_front_porch = 8'h00;
  logic [PORCH_W-1:0] ac_bias_line_count = 8'h01;
  logic ac_bias_per_frame = 1'b1, pal_write = 1'b0, underrun_clear = 1'b0;
  logic [PAL_IDX_W-1:0] pal_index = '0;
  logic [PAL_W-1:0] pal_color = '0;
  // outputs
  logic underrun_flag, pixel_clock, line_pulse, frame_sync, data_enable_out, line_end_pulse, ac_bias_output;
  logic [BUS_W-1:0] video_data_bus;
  logic [RGB_W-1:0] tft_rgb;
  // bench state
  int err_count = 0, n_compared = 0, cyc = 0;
  logic [31:0] w [8];
  // per passive mode: pixel bits, components, msb offsets
  localparam int pw_t[7] = '{1, 2, 4, 8, 12, 16, 16};
  localparam int no_t[7] = '{1, 1, 1, 3, 3, 3, 3};
  localparam int o_t[7][3] = '{'{0, 0, 0}, '{0, 0, 0}, '{0, 0, 0}, '{0, 3, 6}, '{0, 4, 8}, '{4, 8, 12}, '{0, 5, 11}};
  localparam int bpp_t[6] = '{1, 2, 4, 8, 16, 24};
  lcd_pixel_unpack_and_timing uut (.clk, .rst, .word_data, .word_valid, .word_ready, .display_enable,
    .panel_is_tft, .stn_mode, .stn_bus8, .tft_bpp, .pixel_clk_divider, .horiz_size_m1, .vert_size_m1,
    .hsync_width, .horiz_back_porch, .horiz_front_porch, .vsync_width, .vert_back_porch, .vert_front_porch,
    .ac_bias_per_frame, .ac_bias_line_count, .pal_write, .pal_index, .pal_color, .underrun_clear,
    .underrun_flag, .video_data_bus, .tft_rgb, .pixel_clock, .line_pulse, .frame_sync, .data_enable_out,
    .line_end_pulse, .ac_bias_output);
  lcd_panel_model panel (.pixel_clock, .data_enable_out, .video_data_bus, .tft_rgb);
  // 10 MHz clock
  always #50 clk = ~clk;
  // hang guard, far above what the cases need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // one word held until taken, then a gap edge
  task automatic push(input logic [WORD_W-1:0] d);
    int n = 0;
    word_data <= d;
    word_valid <= 1'b1;
    @(posedge clk);
    while (word_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    word_valid <= 1'b0;
    @(posedge clk);
  endtask
  // bit i of the word stream, msb first
  function automatic logic sbit(input int i);
    return w[i / 32][31 - (i % 32)];
  endfunction
  function automatic logic [23:0] field(input int s, input int n);
    logic [23:0] v = '0;
    for (int q = 0; q < n; q++) v = {v[22:0], sbit(s + q)};
    return v;
  endfunction
  // 5:6:5 widened by msb replication
  function automatic logic [23:0] w565(input logic [15:0] c);
    return {c[15:11], c[15:13], c[10:5], c[10:9], c[4:0], c[4:2]};
  endfunction
  task automatic set_words(input int s);
    for (int i = 0; i < 8; i++) w[i] = 32'h9E3779B9 * 32'(i + s);
  endtask
  task automatic wait_cap();
    int n = 0;
    while (panel.byte_q.size() < 8 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // disable flushes the unpacker, clear drops the underrun flag
  task automatic stop(input string nm);
    display_enable <= 1'b0;
    underrun_clear <= 1'b1;
    repeat (4) @(posedge clk);
    underrun_clear <= 1'b0;
    chk("fifo drained", 24'h1, 24'(word_ready));
    chk("underrun clear", 24'h0, 24'(underrun_flag));
    panel.byte_q.delete();
    panel.rgb_q.delete();
    $display("test done: %s", nm);
  endtask
  // first passive line against the word bit stream
  task automatic stn_case(input int m, input logic b8);
    int np = 0, nb;
    logic bq[$];
    logic [7:0] e;
    set_words(m + 1);
    nb = b8 ? 8 : 4;
    while (bq.size() < 8 * nb) begin
      for (int c = 0; c < no_t[m]; c++) bq.push_back(sbit(np * pw_t[m] + o_t[m][c]));
      np++;
    end
    panel_is_tft <= 1'b0;
    stn_mode <= 3'(m);
    stn_bus8 <= b8;
    for (int i = 0; i < (np * pw_t[m] + 31) / 32; i++) push(w[i]);
    display_enable <= 1'b1;
    wait_cap();
    for (int k = 0; k < 8; k++) begin
      e = '0;
      for (int t = 0; t < nb; t++) e = {e[6:0], bq[k * nb + t]};
      chk("panel byte", 24'(e), 24'(panel.byte_q[k]));
    end
    stop("passive unpack");
  endtask
  task automatic tft_case(input int bp);
    int b, nw;
    logic [23:0] v, e;
    set_words(bp + 9);
    b = bpp_t[bp];
    nw = (b == 24) ? 8 : (8 * b + 31) / 32;
    panel_is_tft <= 1'b1;
    tft_bpp <= 3'(bp);
    for (int i = 0; i < nw; i++) push(w[i]);
    if (nw == 8) begin
      repeat (2) @(posedge clk);
      chk("fifo full", 24'h0, 24'(word_ready));
    end
    display_enable <= 1'b1;
    wait_cap();
    for (int j = 0; j < 8; j++) begin
      v = field(j * b, b);
      e = (b == 24) ? w[j][23:0] : (b == 16) ? w565(v[15:0]) : w565({v[7:0], ~v[7:0]});
      chk("tft pixel", e, panel.rgb_q[j]);
    end
    stop("active pixels");
  endtask
  // two frames from frame start; k widens porches
  task automatic timing_case(input int d, input int k);
    int t = 0, t0 = 0, nf = 0, nl = 0, na = 0, c0 = 0, l, f;
    logic pf = 1'b0, pl = 1'b0, pa = 1'b0;
    l = 12 + 2 * k;
    f = 5 + 4 * k;
    pixel_clk_divider <= 10'(d);
    hsync_width <= 8'(k);
    horiz_back_porch <= 8'(k + 1);
    horiz_front_porch <= 8'(k);
    horiz_size_m1 <= 11'(7 - k);
    vsync_width <= 8'(k);
    vert_back_porch <= 8'(k);
    vert_front_porch <= 8'(k);
    vert_size_m1 <= 11'(1 + k);
    ac_bias_per_frame <= (k == 0);
    display_enable <= 1'b1;
    while (nf < 3 && t < 4000) begin
      @(posedge clk);
      t++;
      if (frame_sync && !pf) nf++;
      if (frame_sync && !pf && nf == 1) begin
        t0 = t;
        c0 = panel.byte_q.size();
      end
      if (nf == 1 || nf == 2) begin
        nl += int'(line_pulse && !pl);
        na += int'(ac_bias_output != pa);
      end
      pf = frame_sync;
      pl = line_pulse;
      pa = ac_bias_output;
    end
    chk("frame clocks", 24'(4 * f * l * (d + 1)), 24'(t - t0));
    chk("line starts", 24'(2 * f), 24'(nl));
    chk("enabled beats", 24'(2 * (8 - k) * (2 + k)), 24'(panel.byte_q.size() - c0));
    chk("ac toggles", 24'((k == 0) ? 2 : f), 24'(na));
    chk("underrun set", 24'h1, 24'(underrun_flag));
    stop("raster timing");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int m = 0; m < 7; m++) stn_case(m, m < 4);
    stn_case(0, 1'b0);
    // palette entry i holds {i, ~i}
    for (int i = 0; i < 256; i++) begin
      pal_write <= 1'b1;
      pal_index <= 8'(i);
      pal_color <= {8'(i), ~8'(i)};
      @(posedge clk);
    end
    pal_write <= 1'b0;
    @(posedge clk);
    for (int bp = 0; bp < 6; bp++) tft_case(bp);
    timing_case(0, 0);
    timing_case(2, 1);
    final_report();
  end
endmodule
